/* File: rtl/asc_host.sv */
`include "asc_regs.svh"
module asc_host
  import asc_pkg::*;
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // User request
  input  wire logic                   req_valid,
  input  wire logic                   req_write,
  input  wire logic [`ASC_ADDR_W-1:0] req_addr,
  input  wire logic [`ASC_DATA_W-1:0] req_wdata,
  output logic                        req_ready,
  // User answer
  output logic                        rsp_valid,
  output logic      [`ASC_DATA_W-1:0] rsp_rdata,
  // Memory pins
  output logic      [`ASC_ADDR_W-1:0] address_lines,
  output logic                        chip_select_low,
  output logic                        write_strobe_low,
  input  wire logic [`ASC_DATA_W-1:0] data_lines_in,
  output logic      [`ASC_DATA_W-1:0] data_lines_out,
  output logic                        data_lines_oe
);
  // ----------------------------------------------------------------
  // Pin input filter
  // ----------------------------------------------------------------
  logic [`ASC_DATA_W-1:0] rd_q;
  asc_sync u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin_in  (data_lines_in),
    .pin_q   (rd_q)
  );

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  asc_state_t             st_r, st_nxt;
  logic [`ASC_CNT_W-1:0]  cnt_r, cnt_nxt;
  logic                   wr_r, wr_nxt;
  logic [`ASC_ADDR_W-1:0] addr_r, addr_nxt;
  logic [`ASC_DATA_W-1:0] wdat_r, wdat_nxt, rdat_r, rdat_nxt;
  logic                   cs_r, cs_nxt, we_r, we_nxt, oe_r, oe_nxt;
  logic                   rdy_r, rdy_nxt, rv_r, rv_nxt;
  logic                   take;

  // Read wait covers access time plus the whole filter: three stages and
  // the agreement flop; one cycle less would hand over a stale word
  localparam logic [`ASC_CNT_W-1:0] RD_WAIT = `ASC_CNT_W'(`ASC_ACC_CYC + `ASC_FILT_CYC);
  localparam logic [`ASC_CNT_W-1:0] WR_WAIT = `ASC_CNT_W'(`ASC_WR_CYC);

  // Last cycle of the strobe pulse, decoded alike by all three groups
  function automatic logic pulse_ends(input asc_state_t st, input logic [`ASC_CNT_W-1:0] cnt);
    return (st == ASC_PULSE) && (cnt == `ASC_CNT_ONE);
  endfunction : pulse_ends

  // A request is only taken while idle and ready
  assign take = (st_r == ASC_IDLE) && rdy_r && req_valid;

  // ----------------------------------------------------------------
  // Sequence state, address and write data
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    wr_nxt   = wr_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    case (st_r)
      ASC_IDLE: begin
        if (take) begin
          // Address and data set while both strobes still high
          addr_nxt = req_addr;
          wdat_nxt = req_wdata;
          wr_nxt   = req_write;
          st_nxt   = ASC_SETUP;
        end
      end
      ASC_SETUP: begin
        cnt_nxt = wr_r ? WR_WAIT : RD_WAIT;
        st_nxt  = ASC_PULSE;
      end
      ASC_PULSE: begin
        // Address and data frozen for the whole pulse
        cnt_nxt = cnt_r - `ASC_CNT_ONE;
        if (pulse_ends(st_r, cnt_r)) begin
          st_nxt = ASC_DONE;
        end
      end
      ASC_DONE: begin
        st_nxt = ASC_IDLE;
      end
      default: begin
        st_nxt = ASC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r   <= ASC_IDLE;
      cnt_r  <= `ASC_CNT_ZERO;
      wr_r   <= 1'b0;
      addr_r <= '0;
      wdat_r <= '0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      wr_r   <= wr_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Select, strobe and data drive
  // ----------------------------------------------------------------
  always_comb begin
    cs_nxt = cs_r;
    we_nxt = we_r;
    oe_nxt = oe_r;
    case (st_r)
      ASC_IDLE: begin
        if (take) begin
          // Host drives the data lines for writes only
          oe_nxt = req_write;
        end
      end
      ASC_SETUP: begin
        // Select falls one cycle after address: valid before edge
        cs_nxt = 1'b0;
        we_nxt = !wr_r;
      end
      ASC_PULSE: begin
        // Select stays low until the wait runs out, reads included
        if (pulse_ends(st_r, cnt_r)) begin
          we_nxt = 1'b1;
          cs_nxt = 1'b1;
        end
      end
      ASC_DONE: begin
        // Drive released one cycle after strobes rise
        oe_nxt = 1'b0;
      end
      default: begin
        cs_nxt = 1'b1;
        we_nxt = 1'b1;
        oe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cs_r <= 1'b1;
      we_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      cs_r <= cs_nxt;
      we_r <= we_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // User handshake and read data
  // ----------------------------------------------------------------
  always_comb begin
    rdy_nxt  = rdy_r;
    rv_nxt   = 1'b0;
    rdat_nxt = rdat_r;
    case (st_r)
      ASC_IDLE: begin
        if (take) begin
          rdy_nxt = 1'b0;
        end
      end
      ASC_SETUP: begin
        rdy_nxt = 1'b0;
      end
      ASC_PULSE: begin
        // Filtered word is settled by the last wait cycle
        if (pulse_ends(st_r, cnt_r) && !wr_r) begin
          rdat_nxt = rd_q;
          rv_nxt   = 1'b1;
        end
      end
      ASC_DONE: begin
        rdy_nxt = 1'b1;
      end
      default: begin
        rdy_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdy_r  <= 1'b1;
      rv_r   <= 1'b0;
      rdat_r <= '0;
    end else begin
      rdy_r  <= rdy_nxt;
      rv_r   <= rv_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign req_ready        = rdy_r;
  assign rsp_valid        = rv_r;
  assign rsp_rdata        = rdat_r;
  assign address_lines    = addr_r;
  assign chip_select_low  = cs_r;
  assign write_strobe_low = we_r;
  assign data_lines_out   = wdat_r;
  assign data_lines_oe    = oe_r;
endmodule : asc_host

/* File: rtl/asc_regs.svh */
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
// ----------------------------------------------------------------
// Widths and timing
// ----------------------------------------------------------------
`define ASC_ADDR_W      12
`define ASC_DATA_W      4
`define ASC_CLK_NS      50
// Times in ns as printed
`define ASC_T_ACCESS_NS 25
`define ASC_T_ADDR_WEND_NS 20
`define ASC_T_DSETUP_NS 10
`define ASC_T_PD_NS     25
// Least times round up to whole cycles, never below one
`define ASC_CYC(ns)     ((((ns) + `ASC_CLK_NS - 1) / `ASC_CLK_NS) < 1 ? 1 : (((ns) + `ASC_CLK_NS - 1) / `ASC_CLK_NS))
`define ASC_ACC_CYC     `ASC_CYC(`ASC_T_ACCESS_NS)
`define ASC_WR_CYC      `ASC_CYC(`ASC_T_ADDR_WEND_NS)
// Pin filter latency: three stages plus the agreement flop
`define ASC_FILT_CYC    4
`define ASC_CNT_W       3
`define ASC_CNT_ZERO    3'h0
`define ASC_CNT_ONE     3'h1
`define ASC_SYNC_ZERO   3'h0
`endif

/* File: rtl/asc_pkg.sv */
package asc_pkg;
  typedef enum logic [1:0] {
    ASC_IDLE  = 2'h0,
    ASC_SETUP = 2'h1,
    ASC_PULSE = 2'h3,
    ASC_DONE  = 2'h2
  } asc_state_t;
endpackage : asc_pkg

/* File: rtl/asc_sync.sv */
`include "asc_regs.svh"
module asc_sync (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // Pin in, filtered out
  input  wire logic [`ASC_DATA_W-1:0] pin_in,
  output logic      [`ASC_DATA_W-1:0] pin_q
);
  // ----------------------------------------------------------------
  // Three stages; second and third must agree
  // ----------------------------------------------------------------
  logic [`ASC_DATA_W-1:0] s1_r, s2_r, s3_r, q_r;
  logic [`ASC_DATA_W-1:0] q_nxt;
  always_comb begin
    q_nxt = q_r;
    for (int i = 0; i < `ASC_DATA_W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        q_nxt[i] = s3_r[i];
      end
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end
  assign pin_q = q_r;
endmodule : asc_sync

/* File: testbench/asc_asserts.sv */
// --------
// Pin timing
// --------
module asc_asserts (
  // Watched ports
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic [11:0] address_lines,
  input wire logic        chip_select_low,
  input wire logic        write_strobe_low,
  input wire logic [3:0]  data_lines_out,
  input wire logic        data_lines_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence rd_take_s; req_valid && req_ready && !req_write; endsequence
  sequence rd_sel_s; $fell(chip_select_low) && write_strobe_low; endsequence
  wr_pair_a: assert property (!write_strobe_low |-> !chip_select_low && data_lines_oe)
    else $error("strobe alone");
  wr_end_a: assert property ($rose(write_strobe_low) |-> $stable(data_lines_out) && data_lines_oe)
    else $error("data moved at end");
  wr_addr_hold_a: assert property (!write_strobe_low |=> $stable(address_lines))
    else $error("addr moved");
  wr_addr_set_a: assert property ($fell(write_strobe_low) |-> $stable(address_lines))
    else $error("addr late");
  rd_strobe_a: assert property (rd_take_s |=> write_strobe_low [*7])
    else $error("strobe in read");
  rd_sel_held_a: assert property (rd_sel_s |=> !chip_select_low [*4] ##1 chip_select_low)
    else $error("select dropped");
  rd_addr_set_a: assert property (rd_sel_s |-> $stable(address_lines) && !data_lines_oe)
    else $error("addr late");
  rd_answer_a: assert property (rd_take_s |-> ##7 rsp_valid)
    else $error("no read data");
endmodule : asc_asserts
bind asc_host asc_asserts u_chk (
  .ref_clk          (ref_clk),
  .rst              (rst),
  .req_valid        (req_valid),
  .req_write        (req_write),
  .req_ready        (req_ready),
  .rsp_valid        (rsp_valid),
  .address_lines    (address_lines),
  .chip_select_low  (chip_select_low),
  .write_strobe_low (write_strobe_low),
  .data_lines_out   (data_lines_out),
  .data_lines_oe    (data_lines_oe)
);

/* File: testbench/asc_mem_model.sv */
module asc_mem_model (
  // Pins
  input  wire logic        ref_clk,
  input  wire logic [11:0] address_lines,
  input  wire logic        chip_select_low,
  input  wire logic        write_strobe_low,
  input  wire logic [3:0]  data_lines_out,
  input  wire logic        data_lines_oe,
  output logic      [3:0]  data_lines_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] mem [4096];
  logic [3:0] rd;
  logic [3:0] float_r = 4'h0;
  wire        drv = !chip_select_low && write_strobe_low;
  assign #25 rd = mem[address_lines];
  // Released lines show the inverse of the last driven word, so a stale value never passes
  always @(posedge ref_clk) if (data_lines_oe || drv) float_r <= ~data_lines_in;
  always @(posedge (chip_select_low | write_strobe_low)) mem[address_lines] <= data_lines_in;
  assign data_lines_in = data_lines_oe ? data_lines_out : drv ? rd : float_r;
endmodule : asc_mem_model

/* File: testbench/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, rst, req_valid, req_write, req_ready, rsp_valid;
  logic [11:0] req_addr, address_lines;
  logic [3:0]  req_wdata, rsp_rdata, data_lines_in, data_lines_out;
  logic        chip_select_low, write_strobe_low, data_lines_oe;
  int          fail_count = 0;
  int          checks_done = 0;
  asc_host u_dut (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .req_valid        (req_valid),
    .req_write        (req_write),
    .req_addr         (req_addr),
    .req_wdata        (req_wdata),
    .req_ready        (req_ready),
    .rsp_valid        (rsp_valid),
    .rsp_rdata        (rsp_rdata),
    .address_lines    (address_lines),
    .chip_select_low  (chip_select_low),
    .write_strobe_low (write_strobe_low),
    .data_lines_in    (data_lines_in),
    .data_lines_out   (data_lines_out),
    .data_lines_oe    (data_lines_oe)
  );
  asc_mem_model u_mem (
    .ref_clk          (ref_clk),
    .address_lines    (address_lines),
    .chip_select_low  (chip_select_low),
    .write_strobe_low (write_strobe_low),
    .data_lines_out   (data_lines_out),
    .data_lines_oe    (data_lines_oe),
    .data_lines_in    (data_lines_in)
  );
  // --------
  // Tasks
  // --------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic req(input logic w, input logic [11:0] a, input logic [3:0] d);
    for (int i = 0; i < 20 && req_ready !== 1'b1; i++) @(posedge ref_clk) #1;
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
    @(posedge ref_clk) #1;
    req_valid = 1'b0;
  endtask : req
  task automatic rd(input logic [11:0] a, input logic [3:0] exp);
    int n;
    req(1'b0, a, 4'h0);
    for (n = 0; n < 12 && rsp_valid !== 1'b1; n++) @(posedge ref_clk) #1;
    check(n[15:0], 16'h6);
    check({12'h0, rsp_rdata}, {12'h0, exp});
  endtask : rd
  task automatic t_idle;
    check({11'h0, chip_select_low, write_strobe_low, data_lines_oe, req_ready, rsp_valid}, 16'h1a);
  endtask : t_idle
  task automatic t_midrst;
    req(1'b1, 12'h123, 4'h6);
    @(posedge ref_clk) #1;
    @(posedge ref_clk) #1;
    rst = 1'b1;
    #1 t_idle();
    @(posedge ref_clk) #1;
    rst = 1'b0;
  endtask : t_midrst
  task automatic t_corners;
    req(1'b1, 12'h000, 4'ha);
    req(1'b1, 12'hfff, 4'h5);
    req(1'b1, 12'h000, 4'hf);
    rd(12'h000, 4'hf);
    rd(12'hfff, 4'h5);
  endtask : t_corners
  // --------
  // Clock, sequence and watchdog
  // --------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    {rst, req_valid, req_write, req_addr, req_wdata} = {1'b1, 18'h0};
    repeat (16) @(posedge ref_clk);
    #1 rst = 1'b0;
    t_idle();
    check({4'h0, address_lines}, 16'h0);
    t_midrst();
    t_corners();
    tally_and_finish();
  end
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
endmodule : testbench
